// ===== verilog/sar_adc_comparator_control.sv
`timescale 1ns/1ns
// Overview of operation
// - start of conversion clears the whole 10-bit result before any trial
// - each trial sets the current bit, MSB first, and compares reference to input
// - tried bit stays one if reference below input, else cleared
// - ten trials, MSB down to LSB; final register is the result
// - conversion ends 62 machine cycles after start with result held
// - on completion the done flag sets and the interrupt condition is raised
// - control-one bit 3 high selects comparator mode, low conversion mode
// - compare register write takes A into low nibble, B into high nibble
// - result contents are undefined after switching to comparator mode
// - compare register is separate and survives return to conversion mode
// - compare register is writable and readable only in comparator mode
// - comparator reference is supply times n over 256, n 0 to 255
// - in comparator mode the flag holds outcome, one when input below reference
// - start in comparator mode finishes the comparison after 8 machine cycles
// - flag clears when its interrupt is taken or a skip test skips
// - irq control bit decides interrupt versus polling of the flag
// - low result read puts result bits 1:0 into A bits 3:2, A 1:0 zero
// - flag may set on leaving comparator mode; software clears it by skip test
// - control-one bits 2:0 select one of eight analog inputs
// - control-one resets to zero and is readable and writable
module sar_adc_comparator_control
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic REF_BELOW_INPUT_IN,
  input wire logic IRQ_TAKEN_IN,
  output logic [9:0] DAC_CODE_OUT,
  output logic [2:0] INPUT_SELECT_OUT,
  output logic IRQ_REQ_OUT,
  output logic BUSY_OUT
);
  import sar_pkg::*;

  blk_state_t s_r;
  blk_state_t s_nxt;
  logic req;
  logic wr_ok;
  logic rd_ok;
  logic cmp_mode;
  logic start_go;
  logic set_evt;
  logic set_val;
  logic clr_evt;

  // ==========================================================
  // address match, used by write decoding and start detection; reads decode by case
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // ==========================================================
  // bus request qualification and mode
  assign req = WB_CYC_IN & WB_STB_IN & ~s_r.ack;
  assign wr_ok = req & WB_WE_IN & WB_SEL_IN[0];
  assign rd_ok = req & ~WB_WE_IN;
  assign cmp_mode = s_r.ctrl_one[`BIT_MODE_CMP];
  assign start_go = wr_ok & hit(WB_ADR_IN, `OFS_COMMAND) & WB_DAT_IN[`BIT_CMD_START] & (s_r.st == ST_IDLE);

  // ==========================================================
  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    set_evt = 1'b0;
    set_val = 1'b0;
    clr_evt = 1'b0;
    s_nxt.ack = req;
    s_nxt.rdata = 32'h0000_0000;
    // register writes
    if (wr_ok)
    begin
      if (hit(WB_ADR_IN, `OFS_CTRL_ONE))
        s_nxt.ctrl_one = WB_DAT_IN[3:0];
      if (hit(WB_ADR_IN, `OFS_IRQ_CTRL))
        s_nxt.irq_ctrl = WB_DAT_IN[3:0];
      if (hit(WB_ADR_IN, `OFS_COMPARE) && cmp_mode)
        s_nxt.compare = WB_DAT_IN[7:0];
    end
    // register reads and their side effects
    if (rd_ok)
    begin
      case (WB_ADR_IN)
        `OFS_CTRL_ONE: s_nxt.rdata = {28'h000_0000, s_r.ctrl_one};
        `OFS_IRQ_CTRL: s_nxt.rdata = {28'h000_0000, s_r.irq_ctrl};
        `OFS_SKIP_TEST:
        begin
          s_nxt.rdata = {31'h0000_0000, s_r.flag};
          clr_evt = s_r.flag;
        end
        `OFS_RES_HIGH: s_nxt.rdata = {24'h00_0000, s_r.result[9:2]};
        `OFS_RES_LOW: s_nxt.rdata = {28'h000_0000, s_r.result[1:0], 2'b00};
        `OFS_COMPARE: s_nxt.rdata = cmp_mode ? {24'h00_0000, s_r.compare} : 32'h0000_0000;
        `OFS_STATUS: s_nxt.rdata = {30'h0000_0000, s_r.flag, s_r.st != ST_IDLE};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (IRQ_TAKEN_IN)
      clr_evt = 1'b1;
    // sequencer
    case (s_r.st)
      ST_IDLE:
      begin
        if (start_go)
        begin
          s_nxt.cnt = 6'h00;
          s_nxt.sub = 3'h0;
          s_nxt.idx = 4'h9;
          s_nxt.trials = 4'(`TRIAL_COUNT);
          if (cmp_mode)
            s_nxt.st = ST_COMP;
          else
          begin
            s_nxt.st = ST_CONV;
            s_nxt.result = `RST_RESULT;
          end
        end
      end
      ST_CONV:
      begin
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.trials != 4'h0)
        begin
          if (s_r.sub == 3'h1)
            s_nxt.result[s_r.idx] = 1'b1;
          if (s_r.sub == 3'(`TRIAL_SPACING - 1))
          begin
            if (!REF_BELOW_INPUT_IN)
              s_nxt.result[s_r.idx] = 1'b0;
            s_nxt.idx = s_r.idx - 4'h1;
            s_nxt.trials = s_r.trials - 4'h1;
            s_nxt.sub = 3'h0;
          end
          else
            s_nxt.sub = s_r.sub + 3'h1;
        end
        if (s_r.cnt == 6'(`CONV_CYCLES - 1))
        begin
          s_nxt.st = ST_IDLE;
          set_evt = 1'b1;
          set_val = 1'b1;
        end
      end
      ST_COMP:
      begin
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == 6'(`COMP_CYCLES - 1))
        begin
          s_nxt.st = ST_IDLE;
          set_evt = 1'b1;
          set_val = ~REF_BELOW_INPUT_IN;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // flag: completion wins over a clear in the same cycle
    if (clr_evt)
      s_nxt.flag = 1'b0;
    if (set_evt)
      s_nxt.flag = set_val;
    // reference code: comparator scale n/256 maps to n*4 on 10 bits
    s_nxt.dac = s_nxt.ctrl_one[`BIT_MODE_CMP] ? {s_nxt.compare, 2'b00} : s_nxt.result;
  end

  // ==========================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s_r.st <= ST_IDLE;
      s_r.cnt <= 6'h00;
      s_r.sub <= 3'h0;
      s_r.idx <= 4'h9;
      s_r.trials <= 4'h0;
      s_r.result <= `RST_RESULT;
      s_r.compare <= `RST_COMPARE;
      s_r.ctrl_one <= `RST_CTRL_ONE;
      s_r.irq_ctrl <= `RST_IRQ_CTRL;
      s_r.flag <= 1'b0;
      s_r.dac <= 10'h000;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
    end
    else if (CE_IN)
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign WB_DAT_OUT = s_r.rdata;
  assign WB_ACK_OUT = s_r.ack;
  assign DAC_CODE_OUT = s_r.dac;
  assign INPUT_SELECT_OUT = s_r.ctrl_one[2:0];
  assign IRQ_REQ_OUT = s_r.flag & s_r.irq_ctrl[`BIT_IRQ_EN];
  assign BUSY_OUT = (s_r.st != ST_IDLE);

  // ==========================================================
  // assertions
  a_start_clears: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && start_go && !cmp_mode) |=> (s_r.result == 10'h000 && s_r.st == ST_CONV))
    else $error("conversion start did not clear result");

  a_msb_first: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV && s_r.cnt == 6'h01) |=> s_r.result[9])
    else $error("first trial did not set the top bit");

  a_trial_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV && s_r.trials != 4'h0 && s_r.sub == 3'h5 && REF_BELOW_INPUT_IN)
    |=> s_r.result[$past(s_r.idx)])
    else $error("tried bit lost although reference below input");

  a_trial_drop: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV && s_r.trials != 4'h0 && s_r.sub == 3'h5 && !REF_BELOW_INPUT_IN)
    |=> !s_r.result[$past(s_r.idx)])
    else $error("tried bit kept although reference above input");

  a_conv_end: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV && s_r.cnt == 6'h3D) |=> (s_r.st == ST_IDLE && s_r.flag && s_r.trials == 4'h0))
    else $error("conversion did not end with flag after 62 cycles");

  a_conv_bound: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (s_r.st == ST_CONV) |-> (s_r.cnt < 6'h3E))
    else $error("conversion counter ran past its end");

  a_comp_end: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_COMP && s_r.cnt == 6'h07) |=> (s_r.st == ST_IDLE && s_r.flag == !$past(REF_BELOW_INPUT_IN)))
    else $error("comparison did not finish after 8 cycles with outcome");

  a_irq_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && IRQ_TAKEN_IN && !set_evt) |=> !s_r.flag)
    else $error("flag not cleared by interrupt taken");

  a_low_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_RES_LOW) |=> (WB_DAT_OUT[1:0] == 2'b00 && WB_DAT_OUT[3:2] == $past(s_r.result[1:0])))
    else $error("low result read placed bits wrongly");

  a_cmp_lock: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && wr_ok && WB_ADR_IN == `OFS_COMPARE && !cmp_mode) |=> $stable(s_r.compare))
    else $error("compare register written outside comparator mode");

  // every taken request is answered on the next cycle
  a_ack_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && req) |=> WB_ACK_OUT)
    else $error("bus request not acknowledged");

  // acknowledge lasts a single cycle
  a_ack_single: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && WB_ACK_OUT) |=> !WB_ACK_OUT)
    else $error("acknowledge held longer than one cycle");

  // control-one write lands
  a_ctrl_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && wr_ok && WB_ADR_IN == `OFS_CTRL_ONE) |=> (s_r.ctrl_one == $past(WB_DAT_IN[3:0])))
    else $error("control one write lost");

  // start in comparator mode enters the comparison
  a_comp_entry: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && start_go && cmp_mode) |=> (s_r.st == ST_COMP))
    else $error("comparator start did not begin a comparison");

  // compare write in comparator mode lands whole
  a_cmp_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && wr_ok && WB_ADR_IN == `OFS_COMPARE && cmp_mode) |=> (s_r.compare == $past(WB_DAT_IN[7:0])))
    else $error("compare register write lost");

  // compare read outside comparator mode gives zero
  a_cmp_read_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_COMPARE && !cmp_mode) |=> (WB_DAT_OUT == 32'h0000_0000))
    else $error("compare register readable outside comparator mode");

  // compare read in comparator mode returns the register
  a_cmp_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_COMPARE && cmp_mode) |=> (WB_DAT_OUT[7:0] == $past(s_r.compare)))
    else $error("compare register read wrong");

  // comparator mode drives the scaled compare value
  a_dac_comp: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (s_r.ctrl_one[`BIT_MODE_CMP]) |-> (DAC_CODE_OUT == {s_r.compare, 2'b00}))
    else $error("reference code wrong in comparator mode");

  // conversion mode drives the trial register
  a_dac_conv: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (!s_r.ctrl_one[`BIT_MODE_CMP]) |-> (DAC_CODE_OUT == s_r.result))
    else $error("reference code wrong in conversion mode");

  // input select follows a control-one write
  a_sel_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && wr_ok && WB_ADR_IN == `OFS_CTRL_ONE) |=> (INPUT_SELECT_OUT == $past(WB_DAT_IN[2:0])))
    else $error("input select did not follow control one");

  // busy rises on start
  a_busy_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && start_go) |=> BUSY_OUT)
    else $error("busy not raised by start");

  // busy falls when the comparison ends
  a_busy_drop: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_COMP && s_r.cnt == 6'h07) |=> !BUSY_OUT)
    else $error("busy not dropped at comparison end");

  // a start while busy does not restart the counter
  a_start_ignored: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st != ST_IDLE && wr_ok && WB_ADR_IN == `OFS_COMMAND) |=> (s_r.cnt != 6'h00))
    else $error("start while busy restarted the counter");

  // counter steps once per enabled cycle in conversion
  a_cnt_step: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV) |=> (s_r.cnt == $past(s_r.cnt) + 6'h01))
    else $error("machine cycle counter did not step");

  // counter restarts on start
  a_cnt_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && start_go) |=> (s_r.cnt == 6'h00))
    else $error("machine cycle counter not restarted");

  // low clock enable freezes all state
  a_ce_freeze: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (!CE_IN) |=> $stable(s_r))
    else $error("state changed while clock enable low");

  // enabled interrupt rises when a conversion completes
  a_irq_on_done: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV && s_r.cnt == 6'h3D && s_r.irq_ctrl[`BIT_IRQ_EN]
    && !(wr_ok && hit(WB_ADR_IN, `OFS_IRQ_CTRL))) |=> IRQ_REQ_OUT)
    else $error("interrupt not raised at conversion end");

  // skip test clears a set flag
  a_skip_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_SKIP_TEST && s_r.flag && !set_evt) |=> !s_r.flag)
    else $error("skip test did not clear the flag");

  // completion set wins over a clear
  a_set_wins: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && set_evt && set_val) |=> s_r.flag)
    else $error("completion did not set the flag");

  // compare register untouched by a conversion
  a_cmp_kept: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_CONV) |=> $stable(s_r.compare))
    else $error("compare register changed during conversion");

  // skip test read returns the flag
  a_skip_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_SKIP_TEST) |=> (WB_DAT_OUT == {31'h0000_0000, $past(s_r.flag)}))
    else $error("skip test read wrong");

  // high result read returns the top eight bits
  a_res_high: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_RES_HIGH) |=> (WB_DAT_OUT[7:0] == $past(s_r.result[9:2])))
    else $error("high result read wrong");

  // status read returns flag and busy
  a_status_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_STATUS) |=> (WB_DAT_OUT[1:0] == {$past(s_r.flag), $past(BUSY_OUT)}))
    else $error("status read wrong");

  // finished result stands while idle in conversion mode
  a_result_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && s_r.st == ST_IDLE && !start_go && !cmp_mode) |=> $stable(s_r.result))
    else $error("result changed while idle");

  c_conv_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (s_r.st == ST_CONV) ##1 (s_r.st == ST_IDLE));
  c_comp_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (s_r.st == ST_COMP) ##1 (s_r.st == ST_IDLE && s_r.flag));
  c_skip_clear: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (CE_IN && rd_ok && WB_ADR_IN == `OFS_SKIP_TEST && s_r.flag) ##1 !s_r.flag);
  c_irq_raise: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (BUSY_OUT && s_r.irq_ctrl[`BIT_IRQ_EN]) ##1 IRQ_REQ_OUT);
  c_ce_hold: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (!CE_IN && BUSY_OUT) ##1 !CE_IN);

endmodule

// ===== shared/sar_consts.svh
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// ==========================================================
// register byte offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_IRQ_CTRL 8'h04
`define OFS_COMMAND 8'h08
`define OFS_SKIP_TEST 8'h0C
`define OFS_RES_HIGH 8'h10
`define OFS_RES_LOW 8'h14
`define OFS_COMPARE 8'h18
`define OFS_STATUS 8'h1C

// ==========================================================
// field positions
`define BIT_MODE_CMP 3
`define BIT_IRQ_EN 2
`define BIT_CMD_START 0
`define BIT_STAT_BUSY 0
`define BIT_STAT_FLAG 1

// ==========================================================
// reset values
`define RST_CTRL_ONE 4'h0
`define RST_IRQ_CTRL 4'h0
`define RST_RESULT 10'h000
`define RST_COMPARE 8'h00

// ==========================================================
// timing in machine cycles, and trial count
`define CONV_CYCLES 62
`define COMP_CYCLES 8
`define TRIAL_SPACING 6
`define TRIAL_COUNT 10

`endif

// ===== shared/sar_pkg.sv
package sar_pkg;

  `include "sar_consts.svh"

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_COMP = 2'b10
  } seq_state_t;

  // ==========================================================
  // complete block state
  typedef struct packed
  {
    seq_state_t st;
    logic [5:0] cnt;
    logic [2:0] sub;
    logic [3:0] idx;
    logic [3:0] trials;
    logic [9:0] result;
    logic [7:0] compare;
    logic [3:0] ctrl_one;
    logic [3:0] irq_ctrl;
    logic flag;
    logic [9:0] dac;
    logic ack;
    logic [31:0] rdata;
  } blk_state_t;

endpackage

// ===== bench/analog_input_model.sv
`timescale 1ns/1ns
// ==========================================================
// analog input seen by the comparator, as a 10-bit level
module analog_input_model
(
  input wire logic [9:0] dac_code_in,
  input wire logic [9:0] level_in,
  output logic ref_below_out
);
  // reference is below the input while the dac code is under the level
  assign ref_below_out = (dac_code_in < level_in);
endmodule

// ===== bench/tb_sar_adc_comparator_control.sv
`timescale 1ns/1ns
`include "sar_consts.svh"
module tb_sar_adc_comparator_control;
  import sar_pkg::*;
  logic clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic taken;
  logic ce;
  logic [3:0] lanes;
  logic ack;
  logic below;
  logic irq;
  logic busy;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] dout;
  logic [9:0] level;
  logic [9:0] dac;
  logic [2:0] sel;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  // ==========================================================
  // design and analog side
  sar_adc_comparator_control u_dut
  (
    .CLK_SYS_IN(clk),
    .RST_N_IN(rst_n),
    .CE_IN(ce),
    .WB_CYC_IN(cyc),
    .WB_STB_IN(stb),
    .WB_WE_IN(we),
    .WB_ADR_IN(adr),
    .WB_SEL_IN(lanes),
    .WB_DAT_IN(wdat),
    .WB_DAT_OUT(dout),
    .WB_ACK_OUT(ack),
    .REF_BELOW_INPUT_IN(below),
    .IRQ_TAKEN_IN(taken),
    .DAC_CODE_OUT(dac),
    .INPUT_SELECT_OUT(sel),
    .IRQ_REQ_OUT(irq),
    .BUSY_OUT(busy)
  );
  analog_input_model u_ain
  (
    .dac_code_in(dac),
    .level_in(level),
    .ref_below_out(below)
  );

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task results;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; ack sampled on rising edges, released right after it
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  // start, optionally freeze the clock enable, count cycles until busy falls
  task run_op(input int exp, input int hold);
    wb(1'b1, `OFS_COMMAND, 32'h1);
    n = 1;
    if (hold > 0)
      ce <= 1'b0;
    repeat (hold)
    begin
      @(posedge clk);
      n++;
    end
    ce <= 1'b1;
    while (busy === 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk("op cycles", exp, n);
    @(posedge clk);
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      results;
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    taken = 1'b0;
    ce = 1'b1;
    lanes = 4'hF;
    level = 10'h2A7;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("ctrl one", `OFS_CTRL_ONE, 32'h0);
    // write without byte lane 0 is ignored
    lanes <= 4'h0;
    wb(1'b1, `OFS_CTRL_ONE, 32'h7);
    lanes <= 4'hF;
    rd("ctrl one", `OFS_CTRL_ONE, 32'h0);
    wb(1'b1, `OFS_CTRL_ONE, 32'h5);
    rd("ctrl one", `OFS_CTRL_ONE, 32'h5);
    chk("select", 32'h5, {29'h0, sel});
    run_op(62, 0);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", `OFS_STATUS, 32'h2);
    rd("res high", `OFS_RES_HIGH, 32'hA9);
    rd("res low", `OFS_RES_LOW, 32'h8);
    wb(1'b1, `OFS_IRQ_CTRL, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    rd("skip", `OFS_SKIP_TEST, 32'h1);
    rd("status", `OFS_STATUS, 32'h0);
    // comparator mode with compare value 9C
    wb(1'b1, `OFS_CTRL_ONE, 32'h8);
    wb(1'b1, `OFS_COMPARE, 32'h9C);
    rd("compare", `OFS_COMPARE, 32'h9C);
    chk("dac", 32'h270, {22'h0, dac});
    level <= 10'h100;
    run_op(8, 0);
    rd("status", `OFS_STATUS, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    @(posedge clk);
    rd("status", `OFS_STATUS, 32'h0);
    level <= 10'h3FF;
    run_op(8, 0);
    rd("status", `OFS_STATUS, 32'h0);
    // back to conversion mode, then compare register access
    wb(1'b1, `OFS_IRQ_CTRL, 32'h0);
    wb(1'b1, `OFS_CTRL_ONE, 32'h0);
    wb(1'b0, `OFS_SKIP_TEST, 32'h0);
    rd("status", `OFS_STATUS, 32'h0);
    wb(1'b1, `OFS_COMPARE, 32'h33);
    rd("compare", `OFS_COMPARE, 32'h0);
    wb(1'b1, `OFS_CTRL_ONE, 32'h8);
    rd("compare", `OFS_COMPARE, 32'h9C);
    wb(1'b1, `OFS_CTRL_ONE, 32'h0);
    // stale high result bits must not steer the next conversion
    // three frozen cycles stretch the conversion to 62 plus 3
    level <= 10'h200;
    run_op(65, 3);
    rd("res high", `OFS_RES_HIGH, 32'h7F);
    rd("res low", `OFS_RES_LOW, 32'hC);
    rd("unmapped", 8'h40, 32'h0);
    results;
  end
endmodule
